// ---- hdl/spc_defs.svh ----
// Constants of the combined serial peripheral controller
// What this block does
// - Bit rate at most one eighth clk
// - Word length programmable from 8 to 16
// - Mode 0,0: sample rising, shift falling
// - Mode 0,1: shift rising, sample falling
// - Mode 1,0: sample falling, shift rising
// - Mode 1,1: shift falling, sample rising
// - Master data write starts serial clock
// - Slave frames in either phase bounded by selector
// - Slave words in a frame split by edge count
// - Status read only: done plus exceptions
// - Data write loads shifter, no buffer
// - Received word kept in one buffer
// - Clock count used only as master
// - Push-pull outputs; slave drives when selected
// - Master done after final clock cycle
// - Done clears: status read, then data access
// - Completion with unread data sets overrun
// - Write during transfer sets collision
// - Selector active as master: fault, slave
`ifndef SPC_DEFS_SVH
`define SPC_DEFS_SVH
// Data path width and word length bounds
`define SPC_DATA_W 16
`define SPC_MIN_BITS 5'h08
`define SPC_MAX_BITS 5'h10
// Least clk cycles per serial bit
`define SPC_MIN_DIV 8'h08
// Reset values
`define SPC_RST_WORD 16'h0000
`define SPC_RST_SYNC 3'h1
`endif

// ---- hdl/spc_pkg.sv ----
// Types shared by the serial peripheral controller
package spc_pkg;
  // Configuration set by software before a transfer
  typedef struct packed {
    logic master_en;
    logic clock_polarity;
    logic clock_phase;
    logic [4:0] bit_len;
    logic [7:0] clock_count;
  } spc_cfg_s;
  // Read-only status flags
  typedef struct packed {
    logic transfer_done_flag;
    logic read_overrun_flag;
    logic write_collision_flag;
    logic mode_fault_flag;
  } spc_status_s;
  // Master sequencer states
  typedef enum logic [1:0] {
    SPC_IDLE = 2'b01,
    SPC_RUN = 2'b10
  } spc_state_e;
endpackage

// ---- hdl/spc_sync.sv ----
// Two flip-flop level synchroniser
`timescale 1ns/100ps
`default_nettype none
module spc_sync #(
  parameter int W = 3,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Asynchronous levels in, synchronised out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta; // First stage, read only by q

  // ************************************************
  // Two stage capture
  // ************************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta <= RST;
      q <= RST;
    end
    else
    begin
      meta <= d;
      q <= meta;
    end
  end
endmodule
`default_nettype wire

// ---- hdl/spc_core.sv ----
// Combined master and slave serial peripheral controller
`timescale 1ns/100ps
`default_nettype none
`include "spc_defs.svh"
module spc_core
  import spc_pkg::*;
#(
  parameter int DW = `SPC_DATA_W
) (
  // System clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Processor side
  input wire spc_cfg_s cfg,
  input wire logic data_wr,
  input wire logic [DW-1:0] data_in,
  input wire logic data_rd,
  input wire logic status_rd,
  output logic [DW-1:0] data_out,
  output spc_status_s status,
  // Serial clock pin
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe,
  // Master out slave in pin
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe,
  // Master in slave out pin
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe,
  // Slave select pin, active low
  input wire logic ssel_n
);

  // ************************************************
  // Helper functions
  // ************************************************
  // Clamp the programmed length into 8..16
  function automatic logic [4:0] eff_len(input logic [4:0] l);
    if (l < `SPC_MIN_BITS)
      eff_len = `SPC_MIN_BITS;
    else if (l > `SPC_MAX_BITS)
      eff_len = `SPC_MAX_BITS;
    else
      eff_len = l;
  endfunction

  // Keep only the low len bits of a word
  function automatic logic [DW-1:0] mask_word(input logic [DW-1:0] w, input logic [4:0] l);
    logic [DW-1:0] r;
    r = '0;
    for (int i = 0; i < DW; i++)
      if (i < int'(l))
        r[i] = w[i];
    mask_word = r;
  endfunction

  // ************************************************
  // Declarations
  // ************************************************
  logic [4:0] len; // Effective word length
  logic [3:0] len_m1; // Index of the first bit sent
  logic [2:0] sync_q; // Synchronised ssel, miso, slave toggle
  logic ssel_s; // Synchronised ssel_n
  logic miso_s; // Synchronised miso
  logic s_tgl_s; // Synchronised slave completion toggle
  logic s_tgl_d; // Delayed copy for edge detection
  logic s_done; // Slave word arrived, one clk pulse
  logic master_eff; // Acting as master now
  logic busy; // Transfer in progress
  spc_state_e state; // Master sequencer state
  logic [7:0] div; // Clock count raised to the floor
  logic [6:0] half; // clk cycles per serial half bit
  logic [6:0] hcnt; // Half bit timer
  logic [4:0] ecnt; // Serial edge counter
  logic [3:0] bi; // Next transmit bit index
  logic [DW-1:0] m_rx; // Master receive shifter
  logic [DW-1:0] m_rx_next; // Shifter with current sample
  logic m_edge; // Half bit timer expiry in RUN
  logic m_lead; // Current edge is a leading edge
  logic m_last; // Current edge ends the word
  logic m_done; // Master word finished, one pulse
  logic [DW-1:0] m_word; // Word finished by the master
  logic [DW-1:0] tx_word; // Transmit word, the shift source
  logic armed; // Status read saw done
  logic clr; // Flag clear event
  logic accept_wr; // Data write taken
  logic xfer_end; // Any word finished
  logic take_word; // Finished word enters buffer
  logic [DW-1:0] rx_buf; // Single receive buffer
  logic s_clk; // Slave sampling clock
  logic s_rst_n; // Slave frame reset
  logic [4:0] scnt; // Slave sample counter
  logic [4:0] dcnt; // Slave drive edge counter
  logic [DW-1:0] s_rx; // Slave receive shifter
  logic [DW-1:0] s_hold; // Slave finished word
  logic s_tgl; // Slave completion toggle
  logic [4:0] s_idx; // Slave output bit position
  logic [4:0] s_pos; // Slave bit selected from tx_word

  assign len = eff_len(cfg.bit_len);
  assign len_m1 = 4'(len - 5'h01);

  // ************************************************
  // Pin synchronisers
  // ************************************************
  spc_sync #(
    .W(3),
    .RST(`SPC_RST_SYNC)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({s_tgl, miso_i, ssel_n}),
    .q(sync_q)
  );
  assign ssel_s = sync_q[0];
  assign miso_s = sync_q[1];
  assign s_tgl_s = sync_q[2];

  // Edge detector on the synchronised slave toggle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s_tgl_d <= 1'b0;
    else
      s_tgl_d <= s_tgl_s;
  end
  assign s_done = s_tgl_s ^ s_tgl_d;

  // ************************************************
  // Mode and divider
  // ************************************************
  // Fault forces slave until cleared
  assign master_eff = cfg.master_en & ~status.mode_fault_flag;
  // Divider only matters as master; floor keeps rate at most clk/8
  assign div = (cfg.clock_count < `SPC_MIN_DIV) ? `SPC_MIN_DIV : cfg.clock_count;
  assign half = div[7:1];
  // Slave busy while selected; master busy while running
  assign busy = (state == SPC_RUN) | (~master_eff & ~ssel_s);

  // ************************************************
  // Master sequencer
  // ************************************************
  assign m_edge = (state == SPC_RUN) && (hcnt == 7'(half - 7'h01));
  assign m_lead = ~ecnt[0];
  assign m_last = (ecnt == 5'({len, 1'b0} - 6'h01));
  assign m_rx_next = {m_rx[DW-2:0], miso_s};
  assign m_done = m_edge & m_last;
  // Phase 1 samples on the last edge itself
  assign m_word = mask_word(cfg.clock_phase ? m_rx_next : m_rx, len);

  // State, timer and edge count
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= SPC_IDLE;
      hcnt <= 7'h00;
      ecnt <= 5'h00;
    end
    else
    begin
      case (state)
        SPC_IDLE:
        begin
          hcnt <= 7'h00;
          ecnt <= 5'h00;
          // Data write starts the serial clock
          if (accept_wr && master_eff)
            state <= SPC_RUN;
        end
        SPC_RUN:
        begin
          if (!master_eff)
            // Mode fault drops the word
            state <= SPC_IDLE;
          else if (m_edge)
          begin
            hcnt <= 7'h00;
            ecnt <= 5'(ecnt + 5'h01);
            // Word ends after its final clock cycle
            if (m_last)
              state <= SPC_IDLE;
          end
          else
            hcnt <= 7'(hcnt + 7'h01);
        end
        default:
          state <= SPC_IDLE;
      endcase
    end
  end

  // Serial clock level, idle at the polarity
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      sck_o <= 1'b0;
    else if (state != SPC_RUN)
      sck_o <= cfg.clock_polarity;
    else if (m_edge)
      sck_o <= ~sck_o;
  end

  // Master transmit bit and index
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mosi_o <= 1'b0;
      bi <= 4'h0;
    end
    else if (state == SPC_IDLE && accept_wr && master_eff)
    begin
      if (!cfg.clock_phase)
      begin
        // Phase 0 shows the first bit before the first edge
        mosi_o <= data_in[len_m1];
        bi <= 4'(len_m1 - 4'h1);
      end
      else
        bi <= len_m1;
    end
    else if (m_edge && !m_last)
    begin
      // Phase 0 shifts on trailing edges, phase 1 on leading
      if (m_lead == cfg.clock_phase)
      begin
        mosi_o <= tx_word[bi];
        bi <= 4'(bi - 4'h1);
      end
    end
    else if (m_edge && m_lead && cfg.clock_phase)
      mosi_o <= tx_word[bi];
  end

  // Master receive shifter
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      m_rx <= `SPC_RST_WORD;
    else if (m_edge && (m_lead != cfg.clock_phase))
      // Phase 0 samples on leading, phase 1 on trailing edges
      m_rx <= m_rx_next;
  end

  // ************************************************
  // Data register and flags
  // ************************************************
  assign xfer_end = m_done | s_done;
  // Collision window runs from start until a status read sees done
  assign accept_wr = data_wr & ~busy & (~status.transfer_done_flag | armed);
  assign clr = armed & (data_wr | data_rd);
  assign take_word = xfer_end & (~status.transfer_done_flag | clr);

  // Transmit word written straight to the shift source
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      tx_word <= `SPC_RST_WORD;
    else if (accept_wr)
      tx_word <= data_in;
  end

  // Single receive buffer
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rx_buf <= `SPC_RST_WORD;
    else if (take_word)
      rx_buf <= m_done ? m_word : s_hold;
  end
  assign data_out = rx_buf;

  // Arming by a status read that sees done
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      armed <= 1'b0;
    else if (clr)
      armed <= 1'b0;
    else if (status_rd && status.transfer_done_flag)
      armed <= 1'b1;
  end

  // Done flag, set wins over clear
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      status.transfer_done_flag <= 1'b0;
    else if (xfer_end)
      status.transfer_done_flag <= 1'b1;
    else if (clr)
      status.transfer_done_flag <= 1'b0;
  end

  // Overrun when a word lands on an unread buffer
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      status.read_overrun_flag <= 1'b0;
    else if (xfer_end && !take_word)
      status.read_overrun_flag <= 1'b1;
    else if (clr)
      status.read_overrun_flag <= 1'b0;
  end

  // Collision when a write is refused
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      status.write_collision_flag <= 1'b0;
    else if (data_wr && !accept_wr)
      status.write_collision_flag <= 1'b1;
    else if (clr)
      status.write_collision_flag <= 1'b0;
  end

  // Mode fault when selected while master
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      status.mode_fault_flag <= 1'b0;
    else if (master_eff && !ssel_s)
      status.mode_fault_flag <= 1'b1;
    else if (clr)
      status.mode_fault_flag <= 1'b0;
  end

  // ************************************************
  // Output enables
  // ************************************************
  // Push-pull drive; master always, slave only while selected
  assign sck_oe = master_eff;
  assign mosi_oe = master_eff;
  assign miso_oe = ~master_eff & ~ssel_s;

  // ************************************************
  // Slave link domain
  // ************************************************
  // Sampling edge is rising for modes 0,0 and 1,1
  assign s_clk = sck_i ^ (cfg.clock_polarity ^ cfg.clock_phase);
  // Deselection ends the frame
  assign s_rst_n = rst_n & ~ssel_n;

  // Sample counter and receive shifter
  always_ff @(posedge s_clk or negedge s_rst_n)
  begin
    if (!s_rst_n)
    begin
      scnt <= 5'h00;
      s_rx <= `SPC_RST_WORD;
    end
    else
    begin
      s_rx <= {s_rx[DW-2:0], mosi_i};
      if (scnt == 5'(len - 5'h01))
        scnt <= 5'h00;
      else
        scnt <= 5'(scnt + 5'h01);
    end
  end

  // Word hand-off at the last sampling edge, held across frames
  always_ff @(posedge s_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_hold <= `SPC_RST_WORD;
      s_tgl <= 1'b0;
    end
    else if (scnt == 5'(len - 5'h01))
    begin
      s_hold <= mask_word({s_rx[DW-2:0], mosi_i}, len);
      s_tgl <= ~s_tgl;
    end
  end

  // Drive edge counter
  always_ff @(negedge s_clk or negedge s_rst_n)
  begin
    if (!s_rst_n)
      dcnt <= 5'h00;
    else if (dcnt == 5'(len - 5'h01))
      dcnt <= 5'h00;
    else
      dcnt <= 5'(dcnt + 5'h01);
  end

  // Phase 1 drives the first bit on the first edge
  always_comb
  begin
    s_idx = dcnt;
    if (cfg.clock_phase)
      s_idx = (dcnt == 5'h00) ? 5'(len - 5'h01) : 5'(dcnt - 5'h01);
    s_pos = 5'(len - 5'h01 - s_idx);
  end
  // tx_word holds still while selected
  assign miso_o = tx_word[s_pos[3:0]];

endmodule
`default_nettype wire

// ---- bench/spc_core_props.sv ----
// Port-level assertions for the serial controller
`timescale 1ns/100ps
`default_nettype none
module spc_core_props
  import spc_pkg::*;
#(
  parameter int DW = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Processor side
  input wire spc_cfg_s cfg,
  input wire logic data_wr,
  input wire logic data_rd,
  input wire logic status_rd,
  input wire logic [DW-1:0] data_out,
  input wire spc_status_s status,
  // Pin enables and levels
  input wire logic sck_o,
  input wire logic sck_oe,
  input wire logic mosi_oe,
  input wire logic miso_oe,
  input wire logic ssel_n
);
  // ****
  // Helper state
  // ****
  logic armed; // Status read seen with done set
  // Tracks the first half of the clear handshake
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      armed <= 1'b0;
    else if (data_rd || data_wr)
      armed <= 1'b0;
    else if (status_rd && status.transfer_done_flag)
      armed <= 1'b1;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // ****
  // Assertions
  // ****
  chk_sck_rate: assert property ($changed(sck_o) && sck_oe |=> ($stable(sck_o) || !sck_oe) [*3])
    else $error("serial clock half period too short");
  chk_idle_pol: assert property ($rose(status.transfer_done_flag) && sck_oe |-> sck_o == cfg.clock_polarity)
    else $error("serial clock not idle at done");
  chk_oe_master: assert property (sck_oe |-> cfg.master_en && !status.mode_fault_flag)
    else $error("master drivers on while not master");
  chk_oe_pair: assert property (sck_oe == mosi_oe)
    else $error("master enables disagree");
  chk_miso_sel: assert property (miso_oe |-> !sck_oe && (!$past(ssel_n) || !$past(ssel_n, 2) || !$past(ssel_n, 3)))
    else $error("slave output on while not selected");
  chk_done_hold: assert property ($fell(status.transfer_done_flag) |-> $past(data_rd) || $past(data_wr))
    else $error("done fell without data access");
  chk_flag_clear: assert property ((status_rd && status.transfer_done_flag) ##1 data_rd |=> status == 4'h0)
    else $error("flags not cleared");
  chk_write_collision_flag_set: assert property (data_wr && status.transfer_done_flag && !armed |=> status.write_collision_flag)
    else $error("collision flag not set");
  chk_rx_load: assert property ($changed(data_out) |-> $rose(status.transfer_done_flag))
    else $error("receive buffer changed without completion");
  chk_fault_set: assert property ((cfg.master_en && !ssel_n) [*3] |-> ##[0:2] status.mode_fault_flag)
    else $error("mode fault not raised");
endmodule
bind spc_core spc_core_props #(.DW(DW)) u_props (.clk(clk), .rst_n(rst_n), .cfg(cfg), .data_wr(data_wr),
  .data_rd(data_rd), .status_rd(status_rd), .data_out(data_out), .status(status), .sck_o(sck_o),
  .sck_oe(sck_oe), .mosi_oe(mosi_oe), .miso_oe(miso_oe), .ssel_n(ssel_n));
`default_nettype wire

// ---- bench/spc_peer.sv ----
// Far-side slave model for master transfers
`timescale 1ns/100ps
`default_nettype none
module spc_peer
  import spc_pkg::*;
(
  // Frame enable and settings
  input wire logic go,
  input wire spc_cfg_s cfg,
  input wire logic [15:0] tx,
  // Serial lines
  input wire logic sck,
  input wire logic mosi,
  output logic miso,
  output logic [15:0] rx
);
  int d = 0; // Drive edges this frame
  int i; // Bit now presented
  initial rx = 16'h0000;
  // Shift in on sampling edges, count drive edges
  always @(sck)
  begin
    if (go && sck == (cfg.clock_polarity ~^ cfg.clock_phase))
      rx = {rx[14:0], mosi};
    else if (go)
      d = d + 1;
  end
  // New frame clears the model
  always @(negedge go)
  begin
    d = 0;
    rx = 16'h0000;
  end
  // Phase 0 shows first bit early; out of frame shows inverse of last bit
  always @*
  begin
    i = int'(cfg.bit_len) - 1 - d + int'(cfg.clock_phase);
    if (go && i >= 0 && i < int'(cfg.bit_len))
      miso = tx[i];
    else
      miso = ~tx[0];
  end
endmodule
`default_nettype wire

// ---- bench/tb_top.sv ----
// Self-checking bench for the serial controller
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import spc_pkg::*;
;
  // Row of one master transfer
  typedef struct packed {
    logic pol, pha;
    logic [4:0] len;
    logic [7:0] cnt;
    logic [15:0] tx, peer, rx;
  } spc_row_s;
  spc_row_s rows [4] = '{
    '{1'b0, 1'b0, 5'h08, 8'h08, 16'h00A5, 16'h003C, 16'h003C},
    '{1'b0, 1'b1, 5'h10, 8'h08, 16'hB00F, 16'h6C81, 16'h6C81},
    '{1'b1, 1'b0, 5'h0C, 8'h0A, 16'h0ABC, 16'hF123, 16'h0123},
    '{1'b1, 1'b1, 5'h08, 8'h09, 16'h1E4D, 16'h00C6, 16'h00C6}};
  logic clk = 1'b0, rst_n = 1'b0, data_wr = 1'b0, data_rd = 1'b0, status_rd = 1'b0;
  logic sck_i = 1'b0, mosi_i = 1'b0, ssel_n = 1'b1, go = 1'b0;
  logic sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, pmiso;
  logic [15:0] data_in = 16'h0000, data_out, prx, ptx = 16'h0000;
  spc_cfg_s cfg = '0;
  spc_status_s status;
  int n_errors = 0, n_checks = 0;
  always #10 clk = ~clk;
  spc_core dut (.clk(clk), .rst_n(rst_n), .cfg(cfg), .data_wr(data_wr), .data_in(data_in), .data_rd(data_rd),
    .status_rd(status_rd), .data_out(data_out), .status(status), .sck_i(sck_i), .sck_o(sck_o), .sck_oe(sck_oe),
    .mosi_i(mosi_i), .mosi_o(mosi_o), .mosi_oe(mosi_oe), .miso_i(pmiso), .miso_o(miso_o), .miso_oe(miso_oe),
    .ssel_n(ssel_n));
  spc_peer peer (.go(go), .cfg(cfg), .tx(ptx), .sck(sck_o), .mosi(mosi_o), .miso(pmiso), .rx(prx));
  // ****
  // Tasks
  // ****
  task automatic finish_test;
    $display("checks %0d, mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_flags(input spc_status_s g, input logic [3:0] e);
    chk_word({12'h000, g}, {12'h000, e});
  endtask
  task automatic wr(input logic [15:0] w);
    @(posedge clk);
    data_in <= w;
    data_wr <= 1'b1;
    @(posedge clk);
    data_wr <= 1'b0;
  endtask
  // Status read then data read, then look one edge later
  task automatic clr;
    @(posedge clk);
    status_rd <= 1'b1;
    @(posedge clk);
    status_rd <= 1'b0;
    data_rd <= 1'b1;
    @(posedge clk);
    data_rd <= 1'b0;
    @(posedge clk);
    #1;
    chk_flags(status, 4'h0);
  endtask
  task automatic wait_done(output int n);
    n = 0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end while (status.transfer_done_flag !== 1'b1 && n < 3000);
    if (n >= 3000)
    begin
      n_errors++;
      finish_test();
    end
  endtask
  task automatic do_reset;
    @(posedge clk);
    rst_n <= 1'b0;
    cfg <= '0;
    ssel_n <= 1'b1;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk_flags(status, 4'h0);
    chk_word(data_out, 16'h0000);
    chk_word({13'h0000, sck_oe, mosi_oe, miso_oe}, 16'h0000);
  endtask
  // Bench as master in mode 0: drive on falling, read slave before rising
  task automatic slv(input logic [7:0] w, output logic [7:0] g);
    for (int b = 7; b >= 0; b--)
    begin
      mosi_i = w[b];
      #15;
      g[b] = miso_o;
      sck_i = 1'b1;
      #15;
      sck_i = 1'b0;
    end
    mosi_i = ~w[0];
  endtask
  // Starts a master word with the peer framed
  task automatic start(input spc_cfg_s c, input logic [15:0] p, input logic [15:0] w);
    @(posedge clk);
    go <= 1'b0;
    cfg <= c;
    ptx <= p;
    repeat (2) @(posedge clk);
    go <= 1'b1;
    wr(w);
  endtask
  // ****
  // Main sequence
  // ****
  initial
  begin
    int n;
    logic [15:0] m;
    logic [7:0] g;
    do_reset();
    foreach (rows[i])
    begin
      m = 16'hFFFF >> (16 - rows[i].len);
      start('{1'b1, rows[i].pol, rows[i].pha, rows[i].len, rows[i].cnt}, rows[i].peer, rows[i].tx);
      wait_done(n);
      chk_word(16'(n), 16'(rows[i].len * ((rows[i].cnt < 8) ? 8 : (rows[i].cnt & 8'hFE))));
      chk_word(data_out, rows[i].rx);
      chk_word(prx, rows[i].tx & m);
      chk_flags(status, 4'h8);
      clr();
      $display("row %0d finished", i);
    end
    // Writes while busy and while done is unread are lost
    start('{1'b1, 1'b0, 1'b0, 5'h08, 8'h08}, 16'h0000, 16'h0055);
    repeat (20) @(posedge clk);
    wr(16'h00AA);
    wait_done(n);
    chk_word(prx, 16'h0055);
    wr(16'h00AA);
    @(posedge clk);
    #1;
    chk_flags(status, 4'hA);
    clr();
    $display("collision test finished");
    // Selected while master mid-word
    start('{1'b1, 1'b0, 1'b0, 5'h08, 8'h08}, 16'h0000, 16'h0033);
    repeat (10) @(posedge clk);
    ssel_n <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    chk_flags(status, 4'h1);
    chk_word({14'h0000, sck_oe, mosi_oe}, 16'h0000);
    do_reset();
    $display("mode fault and reset test finished");
    // Slave: two words in one frame without reading the first
    @(posedge clk);
    cfg <= '{1'b0, 1'b0, 1'b0, 5'h08, 8'h08};
    wr(16'h0096);
    ssel_n <= 1'b0;
    repeat (4) @(posedge clk);
    #3;
    slv(8'h5A, g);
    chk_word({8'h00, g}, 16'h0096);
    repeat (8) @(posedge clk);
    #1;
    chk_word(data_out, 16'h005A);
    chk_flags(status, 4'h8);
    slv(8'hC3, g);
    repeat (8) @(posedge clk);
    ssel_n <= 1'b1;
    #1;
    chk_word(data_out, 16'h005A);
    chk_flags(status, 4'hC);
    clr();
    $display("slave overrun test finished");
    finish_test();
  end
endmodule
`default_nettype wire
